// [core/iafc_frame_mem.sv]
/*
 iafc_frame_mem: simple dual-port frame store with registered read data.
 assumes one clock; write and read may hit different words in one cycle.
*/
`timescale 1ns/1ns
module iafc_frame_mem #(
	parameter int unsigned DW = 16,
	parameter int unsigned AW = 12,
	parameter int unsigned DEPTH = 4096
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	// read port, data one cycle after rd_en
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem [DEPTH]; // storage, no reset so it maps to ram

	// write side
	always_ff @(posedge pclk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// read data comes from a register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_data <= '0;
		else if (rd_en)
			rd_data <= mem[rd_addr];
	end
endmodule

// [core/iafc_pkg.sv]
/*
 iafc_pkg: register offsets, field positions, reset values and codes
 shared by the image crop-region and format block.
 assumes a 32-bit apb slave where each register sits in one aligned word.
*/
package iafc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_REDUCE = 8'h04;
	localparam logic [7:0] OFS_CROP_START = 8'h08;
	localparam logic [7:0] OFS_CROP_SIZE = 8'h0c;
	localparam logic [7:0] OFS_STRIDE = 8'h10;
	localparam logic [7:0] OFS_SENSOR = 8'h14;
	localparam logic [7:0] OFS_LIMITS = 8'h18;
	localparam logic [7:0] OFS_FORMAT = 8'h1c;
	localparam logic [7:0] OFS_RANGE = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	// control register bits
	localparam int unsigned CTRL_FLIP_H = 0;
	localparam int unsigned CTRL_FLIP_V = 1;
	// reduce register: four 4-bit factors
	localparam int unsigned HBIN_LSB = 0;
	localparam int unsigned VBIN_LSB = 4;
	localparam int unsigned HSUB_LSB = 8;
	localparam int unsigned VSUB_LSB = 12;
	// a factor after reset means no reduction
	localparam logic [3:0] RST_FACTOR = 4'h1;
	// crop origin after reset is the upper-left pixel
	localparam logic [15:0] RST_CROP_START = 16'h0000;
	// reported pixel encoding and colour mask codes
	localparam logic [7:0] ENC_MONO = 8'h01;
	localparam logic [7:0] MASK_NONE = 8'h00;
	// lowest pixel value produced
	localparam logic [15:0] VALUE_FLOOR = 16'h0000;
	// frame sequencing
	typedef enum logic [0:0] {IAFC_CAPTURE, IAFC_READOUT} iafc_state_e;
endpackage

// [core/iafc_skid2.sv]
/*
 iafc_skid2: two-entry buffer with valid and ready on both sides.
 assumes the source honours in_ready; all outputs come from registers.
*/
`timescale 1ns/1ns
module iafc_skid2 #(
	parameter int unsigned W = 52
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	typedef struct packed {
		logic v0; // head slot holds a word
		logic v1; // second slot holds a word
		logic [W-1:0] d0; // head word
		logic [W-1:0] d1; // second word
	} iafc_buf_s;

	iafc_buf_s st_ff; // registered state
	iafc_buf_s nxt_st; // next state
	logic pop; // head word leaves
	logic push; // new word enters

	assign pop = st_ff.v0 && out_ready;
	assign push = in_valid && !st_ff.v1;
	assign in_ready = !st_ff.v1;
	assign out_valid = st_ff.v0;
	assign out_data = st_ff.d0;

	// shift on pop first, then land a pushed word in the first free slot
	always_comb
	begin
		nxt_st = st_ff;
		if (pop)
		begin
			nxt_st.v0 = st_ff.v1;
			nxt_st.d0 = st_ff.d1;
			nxt_st.v1 = 1'b0;
		end
		if (push)
		begin
			if (!nxt_st.v0)
			begin
				nxt_st.v0 = 1'b1;
				nxt_st.d0 = in_data;
			end
			else
			begin
				nxt_st.v1 = 1'b1;
				nxt_st.d1 = in_data;
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
endmodule

// [core/iafc_top.sv]
/*
 iafc_top: reduces a sensor frame by combining and sub-sampling, stores it,
 then streams a flipped and cropped region with a byte offset per pixel.
 assumes sensor pixels arrive in raster order on pclk with a frame-start
 marker on the first pixel, and an apb master on the same clock.
*/
// Operation
// RULE_01 - reduce sensor frame to reduced limits
// RULE_02 - flip x or y before cropping
// RULE_03 - output exactly width by height pixels
// RULE_04 - offsets measured from upper-left pixel zero
// RULE_05 - all geometry counted in pixels
// RULE_06 - one pixel is one gray value
// RULE_07 - height equals number of output lines
// RULE_08 - line pixels contiguous, padding allowed between
// RULE_09 - line starts spaced by stride bytes
// RULE_10 - pixel format parts readable separately
// RULE_11 - report real lower and upper limits
// RULE_12 - no missing codes within value range
// RULE_13 - reported sensor width above zero
// RULE_14 - combine factor one means no combining
// RULE_15 - subsample factor one means no dropping
// RULE_16 - line sensor reports height one
// RULE_17 - host keeps crop inside reduced frame
// RULE_18 - clamp crop writes outside reduced frame
`timescale 1ns/1ns
module iafc_top #(
	parameter int unsigned SENSOR_COLS = 64,
	parameter int unsigned SENSOR_ROWS = 48,
	parameter bit LINE_SCAN = 1'b0,
	parameter int unsigned PIX_W = 16,
	parameter int unsigned ADC_BITS = 12
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sensor pixel stream
	input wire logic pix_in_valid,
	input wire logic pix_in_sof,
	input wire logic [PIX_W-1:0] pix_in_data,
	output logic pix_in_ready,
	// cropped pixel stream
	output logic pix_out_valid,
	input wire logic pix_out_ready,
	output logic [PIX_W-1:0] pix_out_data,
	output logic [31:0] pix_out_byte_ofs,
	output logic pix_out_sof,
	output logic pix_out_sol,
	output logic pix_out_eol,
	output logic pix_out_eof
);
	localparam int unsigned ROWS_EFF = LINE_SCAN ? 1 : SENSOR_ROWS;
	localparam int unsigned DEPTH = SENSOR_COLS * ROWS_EFF;
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned BPP = (PIX_W + 7) / 8;
	localparam int unsigned BW = PIX_W + 36;
	localparam logic [15:0] COLS16 = 16'(SENSOR_COLS);
	localparam logic [15:0] ROWS16 = 16'(ROWS_EFF);
	localparam logic [31:0] BPP32 = 32'(BPP);
	localparam logic [PIX_W-1:0] CEIL = PIX_W'((1 << ADC_BITS) - 1);

	typedef struct packed {
		iafc_pkg::iafc_state_e state; // capturing or streaming out
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic flip_h; // flip_horizontal
		logic flip_v; // flip_vertical
		logic clamped; // last crop write was adjusted
		logic [3:0] hbin, vbin, hsub, vsub; // combine and subsample factors
		logic [15:0] crop_c, crop_r, crop_w, crop_h; // crop_region in pixels
		logic [31:0] stride; // line_stride_bytes
		logic in_ready;
		logic frame_on; // frame start seen
		logic [15:0] scol, srow; // sensor position
		logic [15:0] rc, rr; // reduced position
		logic [15:0] oc, orow; // output position inside crop
		logic [3:0] hb, hd, vb, vd; // combine and subsample phases
		logic [PIX_W+3:0] acc; // horizontal combine sum
		logic rd_pend, rd_sof, rd_sol, rd_eol, rd_eof; // read in flight
		logic [31:0] rd_ofs, line_ofs; // byte offsets
	} iafc_st_s;

	localparam iafc_st_s ST_RST = '{state: iafc_pkg::IAFC_CAPTURE,
		hbin: iafc_pkg::RST_FACTOR, vbin: iafc_pkg::RST_FACTOR,
		hsub: iafc_pkg::RST_FACTOR, vsub: iafc_pkg::RST_FACTOR,
		crop_c: iafc_pkg::RST_CROP_START, crop_r: iafc_pkg::RST_CROP_START,
		crop_w: COLS16, crop_h: ROWS16, stride: 32'(SENSOR_COLS * BPP),
		in_ready: 1'b1, default: '0};

	iafc_st_s st_ff; // registered state
	iafc_st_s nxt_st; // next state
	logic [7:0] hfac, vfac; // total reduction per axis
	logic [15:0] div_c, div_r, lim_c, lim_r; // reduced_cols_limit, reduced_rows_limit
	logic [32:0] geo_c, geo_r; // clamped crop per axis
	logic [15:0] cs, cw, rs, rh; // crop actually used
	logic wr_en, rd_en;
	logic [AW-1:0] wr_addr, rd_addr;
	logic [PIX_W-1:0] wr_data, mem_rdata;
	logic [15:0] rd_sx; // source column of a read
	logic buf_ready;
	logic [BW-1:0] buf_out;

	// zero factors make no sense; treat them as one
	function automatic logic [3:0] nz_fac(input logic [3:0] f);
		return (f == 4'h0) ? iafc_pkg::RST_FACTOR : f;
	endfunction

	// fit start and size inside lim; bit 32 flags a change
	function automatic logic [32:0] clamp_geom(input logic [15:0] s, input logic [15:0] z,
		input logic [15:0] lim);
		logic [15:0] ns;
		logic [15:0] nz;
		ns = (s >= lim) ? lim - 16'h0001 : s;
		nz = (z == 16'h0000) ? 16'h0001 : z;
		if ({1'b0, ns} + {1'b0, nz} > {1'b0, lim})
			nz = lim - ns;
		return {(ns != s) || (nz != z), ns, nz};
	endfunction

	// offsets that answer without error
	function automatic logic is_mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= iafc_pkg::OFS_STATUS);
	endfunction

	// reduced frame size from sensor size and factors
	assign hfac = {4'h0, st_ff.hbin} * {4'h0, st_ff.hsub};
	assign vfac = {4'h0, st_ff.vbin} * {4'h0, st_ff.vsub};
	assign div_c = COLS16 / {8'h00, hfac}; // RULE_01
	assign div_r = ROWS16 / {8'h00, vfac}; // RULE_01
	assign lim_c = (div_c == 16'h0000) ? 16'h0001 : div_c;
	assign lim_r = (div_r == 16'h0000) ? 16'h0001 : div_r;
	// a factor change after a crop write is caught here again
	assign geo_c = clamp_geom(st_ff.crop_c, st_ff.crop_w, lim_c); // RULE_18
	assign geo_r = clamp_geom(st_ff.crop_r, st_ff.crop_h, lim_r); // RULE_18
	assign cs = geo_c[31:16];
	assign cw = geo_c[15:0];
	assign rs = geo_r[31:16];
	assign rh = geo_r[15:0];

	// register bus, capture and readout in one next-state process
	always_comb
	begin
		logic [15:0] col, row, x, y, sy;
		logic [3:0] hb, hd, vb, vd;
		logic [PIX_W+3:0] sum;
		logic [32:0] g0, g1;
		logic [31:0] rword;
		logic keep_row, last;
		col = '0;
		row = '0;
		x = '0;
		y = '0;
		sy = '0;
		hb = '0;
		hd = '0;
		vb = '0;
		vd = '0;
		sum = '0;
		g0 = '0;
		g1 = '0;
		rword = '0;
		keep_row = 1'b0;
		last = 1'b0;
		nxt_st = st_ff;
		wr_en = 1'b0;
		wr_addr = '0;
		wr_data = '0;
		rd_en = 1'b0;
		rd_addr = '0;
		rd_sx = '0;
		// read mux, each pixel format part stands alone
		case (paddr)
			iafc_pkg::OFS_CTRL: rword = {30'h0, st_ff.flip_v, st_ff.flip_h};
			iafc_pkg::OFS_REDUCE: rword = {16'h0, st_ff.vsub, st_ff.hsub, st_ff.vbin, st_ff.hbin};
			iafc_pkg::OFS_CROP_START: rword = {st_ff.crop_r, st_ff.crop_c};
			iafc_pkg::OFS_CROP_SIZE: rword = {st_ff.crop_h, st_ff.crop_w};
			iafc_pkg::OFS_STRIDE: rword = st_ff.stride;
			iafc_pkg::OFS_SENSOR: rword = {ROWS16, COLS16}; // RULE_13 RULE_16
			iafc_pkg::OFS_LIMITS: rword = {lim_r, lim_c};
			// mono only: one gray value per pixel
			iafc_pkg::OFS_FORMAT: rword = {8'h0, iafc_pkg::MASK_NONE, 8'(PIX_W),
				iafc_pkg::ENC_MONO}; // RULE_06 RULE_10
			iafc_pkg::OFS_RANGE: rword = {16'(CEIL), iafc_pkg::VALUE_FLOOR}; // RULE_10 RULE_11
			iafc_pkg::OFS_STATUS: rword = {30'h0, st_ff.clamped,
				st_ff.state == iafc_pkg::IAFC_READOUT};
			default: rword = 32'h0;
		endcase
		// one wait state: pready rises in the second access cycle
		nxt_st.pready = psel && penable && !st_ff.pready;
		nxt_st.prdata = nxt_st.pready ? rword : 32'h0;
		nxt_st.pslverr = nxt_st.pready && !is_mapped(paddr);
		// writes land only on the edge that completes the transfer
		if (psel && penable && st_ff.pready && pwrite)
		begin
			case (paddr)
				iafc_pkg::OFS_CTRL:
				begin
					nxt_st.flip_h = pwdata[iafc_pkg::CTRL_FLIP_H];
					nxt_st.flip_v = pwdata[iafc_pkg::CTRL_FLIP_V];
				end
				iafc_pkg::OFS_REDUCE:
				begin
					nxt_st.hbin = nz_fac(pwdata[iafc_pkg::HBIN_LSB +: 4]);
					nxt_st.vbin = nz_fac(pwdata[iafc_pkg::VBIN_LSB +: 4]);
					nxt_st.hsub = nz_fac(pwdata[iafc_pkg::HSUB_LSB +: 4]);
					nxt_st.vsub = nz_fac(pwdata[iafc_pkg::VSUB_LSB +: 4]);
				end
				iafc_pkg::OFS_CROP_START, iafc_pkg::OFS_CROP_SIZE:
				begin
					// new half paired with the stored other half, then fitted
					if (paddr == iafc_pkg::OFS_CROP_START)
					begin
						g0 = clamp_geom(pwdata[15:0], st_ff.crop_w, lim_c); // RULE_18
						g1 = clamp_geom(pwdata[31:16], st_ff.crop_h, lim_r); // RULE_18
					end
					else
					begin
						g0 = clamp_geom(st_ff.crop_c, pwdata[15:0], lim_c); // RULE_18
						g1 = clamp_geom(st_ff.crop_r, pwdata[31:16], lim_r); // RULE_18
					end
					nxt_st.crop_c = g0[31:16];
					nxt_st.crop_w = g0[15:0];
					nxt_st.crop_r = g1[31:16];
					nxt_st.crop_h = g1[15:0];
					nxt_st.clamped = g0[32] || g1[32];
				end
				iafc_pkg::OFS_STRIDE: nxt_st.stride = pwdata;
				default: ;
			endcase
		end
		case (st_ff.state)
			iafc_pkg::IAFC_CAPTURE:
			begin
				// pixels before the first frame start are dropped
				if (pix_in_valid && st_ff.in_ready && (st_ff.frame_on || pix_in_sof))
				begin
					if (!pix_in_sof)
					begin
						col = st_ff.scol;
						row = st_ff.srow;
						hb = st_ff.hb;
						hd = st_ff.hd;
						vb = st_ff.vb;
						vd = st_ff.vd;
						sum = st_ff.acc;
						nxt_st.rc = st_ff.rc;
						nxt_st.rr = st_ff.rr;
					end
					else
					begin
						nxt_st.rc = '0;
						nxt_st.rr = '0;
					end
					nxt_st.frame_on = 1'b1;
					sum = sum + {4'h0, pix_in_data};
					// vertical combining keeps the first row of each group
					keep_row = (vb == 4'h0) && (vd == 4'h0);
					nxt_st.acc = sum;
					nxt_st.hb = hb + 4'h1;
					// factor one closes a group on every cell
					if (hb >= st_ff.hbin - 4'h1) // RULE_14
					begin
						// saturation keeps every code up to the ceiling reachable
						wr_data = (sum > {4'h0, CEIL}) ? CEIL : sum[PIX_W-1:0]; // RULE_12
						wr_en = keep_row && (hd == 4'h0) && (nxt_st.rc < lim_c); // RULE_15
						wr_addr = AW'(32'(nxt_st.rr) * SENSOR_COLS + 32'(nxt_st.rc));
						if (hd == 4'h0)
							nxt_st.rc = nxt_st.rc + 16'h1;
						nxt_st.hd = (hd >= st_ff.hsub - 4'h1) ? 4'h0 : hd + 4'h1; // RULE_15
						nxt_st.hb = 4'h0;
						nxt_st.acc = '0;
					end
					else
						nxt_st.hd = hd;
					nxt_st.scol = col + 16'h1;
					nxt_st.srow = row;
					nxt_st.vb = vb;
					nxt_st.vd = vd;
					// end of a sensor line: phases restart, rows advance
					if (col >= COLS16 - 16'h1)
					begin
						nxt_st.scol = '0;
						nxt_st.hb = '0;
						nxt_st.hd = '0;
						nxt_st.acc = '0;
						nxt_st.rc = '0;
						if (keep_row && nxt_st.rr < lim_r)
							nxt_st.rr = nxt_st.rr + 16'h1;
						if (vb >= st_ff.vbin - 4'h1) // RULE_14
						begin
							nxt_st.vb = 4'h0;
							nxt_st.vd = (vd >= st_ff.vsub - 4'h1) ? 4'h0 : vd + 4'h1; // RULE_15
						end
						else
							nxt_st.vb = vb + 4'h1;
						nxt_st.srow = row + 16'h1;
						// whole frame stored: stop input and stream out
						if (row >= ROWS16 - 16'h1)
						begin
							nxt_st.state = iafc_pkg::IAFC_READOUT;
							nxt_st.in_ready = 1'b0;
							nxt_st.frame_on = 1'b0;
							nxt_st.oc = '0;
							nxt_st.orow = '0;
							nxt_st.line_ofs = '0;
						end
					end
				end
			end
			iafc_pkg::IAFC_READOUT:
			begin
				// one read at a time; the buffer always has room when it lands
				if (!st_ff.rd_pend && buf_ready)
				begin
					x = cs + st_ff.oc; // RULE_04
					y = rs + st_ff.orow; // RULE_04
					// flip in the reduced frame, then pick the crop
					rd_sx = st_ff.flip_h ? lim_c - 16'h1 - x : x; // RULE_02
					sy = st_ff.flip_v ? lim_r - 16'h1 - y : y; // RULE_02
					rd_en = 1'b1;
					rd_addr = AW'(32'(sy) * SENSOR_COLS + 32'(rd_sx));
					last = st_ff.oc >= cw - 16'h1; // RULE_03
					nxt_st.rd_sol = st_ff.oc == 16'h0;
					nxt_st.rd_sof = (st_ff.oc == 16'h0) && (st_ff.orow == 16'h0);
					nxt_st.rd_eol = last;
					nxt_st.rd_eof = last && (st_ff.orow >= rh - 16'h1); // RULE_07
					// pixels of a line sit back to back, BPP bytes apart
					nxt_st.rd_ofs = st_ff.line_ofs + 32'(st_ff.oc) * BPP32; // RULE_05 RULE_08
					nxt_st.oc = st_ff.oc + 16'h1;
					if (last)
					begin
						nxt_st.oc = '0;
						nxt_st.orow = st_ff.orow + 16'h1;
						// gap up to the stride is padding
						nxt_st.line_ofs = st_ff.line_ofs + st_ff.stride; // RULE_09
						if (nxt_st.rd_eof)
						begin
							nxt_st.state = iafc_pkg::IAFC_CAPTURE;
							nxt_st.in_ready = 1'b1;
						end
					end
				end
			end
			default: nxt_st.state = iafc_pkg::IAFC_CAPTURE;
		endcase
		nxt_st.rd_pend = rd_en;
	end

	// single state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	// whole reduced frame is kept so both flips work
	iafc_frame_mem #(.DW(PIX_W), .AW(AW), .DEPTH(DEPTH)) u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(mem_rdata)
	);

	// output buffer, a stalled receiver holds the readout
	iafc_skid2 #(.W(BW)) u_buf (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(st_ff.rd_pend),
		.in_ready(buf_ready),
		.in_data({st_ff.rd_eof, st_ff.rd_sof, st_ff.rd_eol, st_ff.rd_sol, st_ff.rd_ofs,
			mem_rdata}),
		.out_valid(pix_out_valid),
		.out_ready(pix_out_ready),
		.out_data(buf_out)
	);

	assign {pix_out_eof, pix_out_sof, pix_out_eol, pix_out_sol, pix_out_byte_ofs,
		pix_out_data} = buf_out;
	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign pix_in_ready = st_ff.in_ready;

	// helper counters for the checks below
	logic pop;
	logic [31:0] ocnt, rcnt, last_ofs;
	assign pop = pix_out_valid && pix_out_ready;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ocnt <= '0;
			rcnt <= '0;
			last_ofs <= '0;
		end
		else if (pop)
		begin
			ocnt <= pix_out_eof ? 32'h0 : ocnt + 32'h1;
			last_ofs <= pix_out_byte_ofs;
			if (pix_out_eol)
				rcnt <= pix_out_eof ? 32'h0 : rcnt + 32'h1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence
	chk_apb_one_wait: assert property (s_access ##1 s_done |=> !pready)
		else $error("apb answer not one wait state");
	// read data stands only in the cycle that completes the read, so look there
	chk_sensor_width: assert property (s_done |-> // RULE_13
		!((paddr == iafc_pkg::OFS_SENSOR) && (prdata[15:0] == 16'h0)))
		else $error("sensor width read as zero");
	chk_crop_inside: assert property ({1'b0, cs} + {1'b0, cw} <= {1'b0, lim_c} && // RULE_18
		{1'b0, rs} + {1'b0, rh} <= {1'b0, lim_r})
		else $error("crop region leaves reduced frame");
	chk_frame_pixels: assert property (pop && pix_out_eof |-> ocnt + 32'h1 == // RULE_03
		32'(cw) * 32'(rh))
		else $error("frame pixel count differs from width by height");
	chk_frame_lines: assert property (pop && pix_out_eof |-> rcnt + 32'h1 == 32'(rh)) // RULE_07
		else $error("frame line count differs from height");
	chk_line_stride: assert property (pop && pix_out_sol |-> pix_out_byte_ofs == // RULE_09
		32'(rcnt * st_ff.stride))
		else $error("line start not at stride multiple");
	chk_line_contig: assert property (pop && !pix_out_sol |-> pix_out_byte_ofs == // RULE_08
		last_ofs + BPP32)
		else $error("pixels of a line not contiguous");
	chk_origin_zero: assert property (pop && pix_out_sof |-> pix_out_sol && // RULE_04
		pix_out_byte_ofs == 32'h0)
		else $error("frame does not start at offset zero");
	chk_flip_first: assert property (rd_en && st_ff.oc == 16'h0 && st_ff.flip_h |-> // RULE_02
		rd_sx == lim_c - 16'h1 - cs)
		else $error("flipped line does not start at mirrored column");
	chk_value_ceiling: assert property (wr_en |-> wr_data <= CEIL) // RULE_11
		else $error("pixel above reported ceiling");
endmodule

// [testbench/iafc_sensor_model.sv]
/*
 iafc_sensor_model: behavioural sensor readout feeding raster frames.
 assumes one clock; a start pulse launches one frame, pixel {row,col}.
*/
`timescale 1ns/1ns
module iafc_sensor_model #(
	parameter int unsigned COLS = 8,
	parameter int unsigned ROWS = 6
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// frame request from the bench
	input wire logic start,
	// pixel stream toward the block
	output logic valid,
	output logic sof,
	output logic [15:0] data,
	input wire logic ready
);
	int unsigned idx; // raster index of the pixel on offer
	logic busy; // a frame is running
	// each word is held until taken; idle data toggles so no stale value looks valid
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy <= 1'b0;
			idx <= 0;
			valid <= 1'b0;
			sof <= 1'b0;
			data <= 16'h0000;
		end
		else if (!busy)
		begin
			valid <= start;
			sof <= start;
			busy <= start;
			idx <= 0;
			data <= start ? 16'h0000 : ~data;
		end
		else if (valid && ready)
		begin
			// last pixel of the frame taken: go idle
			if (idx == COLS * ROWS - 1)
			begin
				busy <= 1'b0;
				valid <= 1'b0;
				data <= ~data;
			end
			else
			begin
				idx <= idx + 1;
				data <= {8'((idx + 1) / COLS), 8'((idx + 1) % COLS)};
			end
			sof <= 1'b0;
		end
	end
endmodule

// [testbench/iafc_tb_top.sv]
/*
 iafc_tb_top: self-checking bench for the crop-region and format block.
 assumes a small 8x6 sensor, 16-bit pixels, apb master tasks below.
*/
`timescale 1ns/1ns
module iafc_tb_top;
	localparam int unsigned COLS = 8;
	localparam int unsigned ROWS = 6;
	logic pclk = 1'b0, presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, start = 1'b0;
	logic in_valid, in_sof, in_ready, out_valid, out_ready = 1'b0;
	logic [15:0] in_data, out_data;
	logic [31:0] out_ofs;
	logic out_sof, out_sol, out_eol, out_eof;
	int err_count = 0, compares = 0;
	iafc_top #(.SENSOR_COLS(COLS), .SENSOR_ROWS(ROWS), .PIX_W(16), .ADC_BITS(12)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pix_in_valid(in_valid), .pix_in_sof(in_sof), .pix_in_data(in_data),
		.pix_in_ready(in_ready), .pix_out_valid(out_valid), .pix_out_ready(out_ready),
		.pix_out_data(out_data), .pix_out_byte_ofs(out_ofs), .pix_out_sof(out_sof),
		.pix_out_sol(out_sol), .pix_out_eol(out_eol), .pix_out_eof(out_eof));
	iafc_sensor_model #(.COLS(COLS), .ROWS(ROWS)) i_sensor (.pclk(pclk), .presetn(presetn),
		.start(start), .valid(in_valid), .sof(in_sof), .data(in_data), .ready(in_ready));
	// 250 MHz clock
	initial
	begin
		forever #2 pclk = ~pclk;
	end
	// one comparison, reported at once on mismatch
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		chk(n < 50, 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge, so a following call never re-drives psel in this time step
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0, rd, er);
		chk(rd, exp);
	endtask
	// identity, limit and reset-value registers straight after reset, then an unmapped read
	task automatic t_reset_regs();
		logic [31:0] rd;
		logic er;
		rdchk(iafc_pkg::OFS_SENSOR, {16'(ROWS), 16'(COLS)});
		rdchk(iafc_pkg::OFS_LIMITS, {16'(ROWS), 16'(COLS)});
		rdchk(iafc_pkg::OFS_REDUCE, 32'h0000_1111);
		rdchk(iafc_pkg::OFS_FORMAT, {8'h00, iafc_pkg::MASK_NONE, 8'h10, iafc_pkg::ENC_MONO});
		rdchk(iafc_pkg::OFS_RANGE, {16'h0fff, iafc_pkg::VALUE_FLOOR});
		rdchk(iafc_pkg::OFS_CROP_START, 32'h0);
		apb(1'b0, 8'h28, 32'h0, rd, er);
		chk({31'h0, er}, 32'h1);
	endtask
	// crop 3x2 at col 1 row 2 with flips; sink stalls two cycles in four
	task automatic t_crop(input logic [1:0] flip);
		int k, n, x, y, c, r;
		wr(iafc_pkg::OFS_CTRL, {30'h0, flip});
		wr(iafc_pkg::OFS_CROP_START, 32'h0002_0001);
		wr(iafc_pkg::OFS_CROP_SIZE, 32'h0002_0003);
		wr(iafc_pkg::OFS_STRIDE, 32'h0000_0020);
		start <= 1'b1;
		@(posedge pclk);
		start <= 1'b0;
		k = 0;
		n = 0;
		while (k < 6 && n < 3000)
		begin
			@(posedge pclk);
			n++;
			if (out_valid === 1'b1 && out_ready === 1'b1)
			begin
				y = k / 3;
				x = k % 3;
				c = flip[0] ? COLS - 2 - x : 1 + x;
				r = flip[1] ? ROWS - 3 - y : 2 + y;
				chk(out_data, {16'h0, 8'(r), 8'(c)});
				chk(out_ofs, y * 32 + x * 2);
				chk({out_sof, out_sol, out_eol, out_eof}, {k == 0, x == 0, x == 2, k == 5});
				k++;
			end
			out_ready <= n[1];
		end
		chk(k, 6);
		out_ready <= 1'b1;
		repeat (20) @(posedge pclk);
		chk({out_valid, in_ready}, 2'b01);
	endtask
	// out-of-range origin is clamped; subsample halves the limit; factor 0 reads 1
	task automatic t_geometry();
		wr(iafc_pkg::OFS_CROP_START, 32'h0000_0014);
		rdchk(iafc_pkg::OFS_CROP_START, 32'(COLS - 1));
		rdchk(iafc_pkg::OFS_STATUS, 32'h0000_0002);
		wr(iafc_pkg::OFS_REDUCE, 32'h0000_1211);
		rdchk(iafc_pkg::OFS_LIMITS, {16'(ROWS), 16'(COLS / 2)});
		wr(iafc_pkg::OFS_REDUCE, 32'h0000_0000);
		rdchk(iafc_pkg::OFS_REDUCE, 32'h0000_1111);
	endtask
	// verdict and end of run
	task automatic test_done();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// watchdog, far beyond the expected run
	initial
	begin
		#200000;
		err_count++;
		test_done();
	end
	// main sequence
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset_regs();
		t_crop(2'b00);
		t_crop(2'b01);
		t_crop(2'b10);
		t_geometry();
		test_done();
	end
endmodule
